/* File: rtl/card_bridge_pkg.sv */
// What this block does
// - global reset: outputs off, registers to default
// - suspend keeps registers through global reset, except the pme status, which global reset clears
// - bus reset: outputs off, supply select registers reset, wake enable kept
// - pme during bus reset only if enabled
// - after bus reset release, default state
// - suspend keeps registers through bus reset
// - all inputs sampled on rising clock edge
// - drive two main and two prog selects
`default_nettype none
package card_bridge_pkg;
  // ==========================================================
  // reset values
  localparam logic [1:0] MAIN_SEL_RST = 2'h0;
  localparam logic [1:0] PROG_SEL_RST = 2'h0;
  localparam logic PME_EN_RST = 1'b0;
  // ==========================================================
  // reset source state
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_HOLD = 2'h1,
    ST_SUSP = 2'h3
  } reset_state_t;
endpackage
`default_nettype wire

/* File: rtl/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1_r;
  // ==========================================================
  // two-stage synchroniser, first stage read only by second
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      stage1_r <= '0;
      o_sync <= '0;
    end
    else
    begin
      stage1_r <= i_async;
      o_sync <= stage1_r;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/card_bridge_reset_suspend.sv */
`timescale 1ns/1ps
`default_nettype none
module card_bridge_reset_suspend (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_global_reset_in,
  input wire logic i_bus_reset_in,
  input wire logic i_suspend,
  input wire logic i_regulator_enable_n,
  input wire logic i_cfg_we,
  input wire logic [1:0] i_cfg_main_sel,
  input wire logic [1:0] i_cfg_prog_sel,
  input wire logic i_cfg_pme_en,
  input wire logic i_pme_event,
  output logic o_card_main_supply_sel0,
  output logic o_card_main_supply_sel1,
  output logic o_card_prog_supply_sel0,
  output logic o_card_prog_supply_sel1,
  output logic o_supply_sel_oe,
  output logic o_pme_n_out,
  output logic o_pme_n_oe,
  output logic o_regulator_internal,
  output logic [1:0] o_state
);
  // synchronised pins
  logic [3:0] pins_s;
  logic global_reset_in_s;
  logic bus_reset_in_s;
  logic susp_s;
  logic vren_n_s;

  // reset qualifiers
  logic any_rst;
  logic regs_clear;
  logic pme_en_clear;
  logic pme_clear;
  logic cfg_take;

  // registers
  logic [1:0] main_sel_r;
  logic [1:0] prog_sel_r;
  logic pme_en_r;
  logic pme_r;
  logic pme_oe;
  logic regulator_internal_r;
  card_bridge_pkg::reset_state_t state_r;
  card_bridge_pkg::reset_state_t state_nxt;

  // ==========================================================
  // pin inputs, sampled on rising edge
  pin_sync #(.WIDTH(4)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_async({i_global_reset_in, i_bus_reset_in, i_suspend, i_regulator_enable_n}),
    .o_sync(pins_s)
  );
  assign global_reset_in_s = pins_s[3];
  assign bus_reset_in_s = pins_s[2];
  assign susp_s = pins_s[1];
  assign vren_n_s = pins_s[0];

  // ==========================================================
  // reset qualifiers
  // either reset takes the pins off the bus, suspend or not
  assign any_rst = global_reset_in_s | bus_reset_in_s;
  // suspend shields the registers except pme status, never the pins
  assign regs_clear = any_rst && !susp_s;
  // bus reset leaves the wake enable alone so pme can still be raised
  assign pme_en_clear = global_reset_in_s && !susp_s;
  assign pme_clear = global_reset_in_s;
  // writes are refused while either reset is seen
  // limitation: a write up to two cycles after a reset pin rises still lands
  assign cfg_take = i_cfg_we && !any_rst;

  // ==========================================================
  // reset state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      card_bridge_pkg::ST_RUN:
      begin
        if (any_rst && susp_s)
          state_nxt = card_bridge_pkg::ST_SUSP;
        else if (any_rst)
          state_nxt = card_bridge_pkg::ST_HOLD;
        else
          state_nxt = card_bridge_pkg::ST_RUN;
      end
      card_bridge_pkg::ST_HOLD:
      begin
        if (!any_rst)
          state_nxt = card_bridge_pkg::ST_RUN;
        else if (susp_s)
          state_nxt = card_bridge_pkg::ST_SUSP;
        else
          state_nxt = card_bridge_pkg::ST_HOLD;
      end
      card_bridge_pkg::ST_SUSP:
      begin
        if (!any_rst)
          state_nxt = card_bridge_pkg::ST_RUN;
        else if (susp_s)
          state_nxt = card_bridge_pkg::ST_SUSP;
        else
          state_nxt = card_bridge_pkg::ST_HOLD;
      end
      default:
      begin
        state_nxt = card_bridge_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_r <= card_bridge_pkg::ST_RUN;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // supply selects; suspend shields them from both resets
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || regs_clear)
    begin
      main_sel_r <= card_bridge_pkg::MAIN_SEL_RST;
    end
    else if (cfg_take)
    begin
      main_sel_r <= i_cfg_main_sel;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || regs_clear)
    begin
      prog_sel_r <= card_bridge_pkg::PROG_SEL_RST;
    end
    else if (cfg_take)
    begin
      prog_sel_r <= i_cfg_prog_sel;
    end
  end

  // ==========================================================
  // wake enable, cleared by an unshielded global reset only
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || pme_en_clear)
    begin
      pme_en_r <= card_bridge_pkg::PME_EN_RST;
    end
    else if (cfg_take)
    begin
      pme_en_r <= i_cfg_pme_en;
    end
  end

  // ==========================================================
  // pme status; an event wins over a clearing write in one cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset || pme_clear)
    begin
      pme_r <= 1'h0;
    end
    else if (!pme_en_r)
    begin
      pme_r <= 1'h0;
    end
    else if (i_pme_event)
    begin
      pme_r <= 1'h1;
    end
    else if (!bus_reset_in_s && i_cfg_we)
    begin
      pme_r <= 1'h0;
    end
  end

  // ==========================================================
  // pme pin: the one output allowed out during a bus reset
  always_comb
  begin
    pme_oe = 1'h0;
    if (pme_r && !global_reset_in_s)
    begin
      pme_oe = !bus_reset_in_s || pme_en_r;
    end
  end

  // ==========================================================
  // regulator strap, registered so the status pin is a flop output
  // the strap is static in a real system, so three cycles of lag (two sync stages plus this register) are harmless
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      regulator_internal_r <= 1'h0;
    end
    else
    begin
      regulator_internal_r <= !vren_n_s;
    end
  end

  // ==========================================================
  // outputs: released only while no reset holds them
  assign o_supply_sel_oe = !any_rst;

  assign o_card_main_supply_sel0 = main_sel_r[0];
  assign o_card_main_supply_sel1 = main_sel_r[1];
  assign o_card_prog_supply_sel0 = prog_sel_r[0];
  assign o_card_prog_supply_sel1 = prog_sel_r[1];

  // open drain: the pin is only ever pulled low
  assign o_pme_n_out = 1'h0;
  assign o_pme_n_oe = pme_oe;
  assign o_regulator_internal = regulator_internal_r;
  assign o_state = state_r;
endmodule
`default_nettype wire

/* File: tb/bridge_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// pin reset checks
module bridge_sva (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_global_reset_in,
  input wire logic i_bus_reset_in,
  input wire logic i_suspend,
  input wire logic i_cfg_we,
  input wire logic i_pme_event,
  input wire logic o_card_main_supply_sel0,
  input wire logic o_supply_sel_oe,
  input wire logic o_pme_n_oe,
  input wire logic [1:0] i_cfg_main_sel,
  input wire logic [1:0] o_state
);
  wire logic g = i_global_reset_in;
  wire logic b = i_bus_reset_in;
  wire logic s = i_suspend;
  wire logic m = o_card_main_supply_sel0;
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  // three samples for the enable (two sync stages), four for registers: two sync stages plus the register update
  a_global_reset_in_oe_off: assert property (g[*3] |-> !o_supply_sel_oe)
    else $error("oe on");
  a_global_reset_in_regs_clear: assert property ((g && !s)[*4] |-> !m && !o_pme_n_oe)
    else $error("regs kept");
  a_global_reset_in_susp_keep: assert property ((g && s)[*4] |-> $stable(m))
    else $error("regs lost");
  a_bus_reset_in_regs_reset: assert property ((b && !s)[*4] |-> !m && !o_supply_sel_oe)
    else $error("bus reset");
  a_pme_needs_event: assert property ($rose(o_pme_n_oe) |-> $past(i_pme_event))
    else $error("pme cause");
  a_bus_reset_in_release_run: assert property ($fell(b) && !g |-> ##[1:4]
    (o_supply_sel_oe && o_state == card_bridge_pkg::ST_RUN)) else $error("no run");
  a_bus_reset_in_susp_keep: assert property ((b && s)[*4] |-> $stable(m) && !o_supply_sel_oe)
    else $error("susp");
  a_write_loads_sel: assert property (i_cfg_we && o_supply_sel_oe
    |=> m == $past(i_cfg_main_sel[0])) else $error("sel");
  c_pme: cover property ($rose(o_pme_n_oe));
  c_susp: cover property (o_state == card_bridge_pkg::ST_SUSP);
  c_write: cover property (i_cfg_we && o_supply_sel_oe);
endmodule
bind card_bridge_reset_suspend bridge_sva u_bridge_sva (.i_clk_sys, .i_reset,
  .i_global_reset_in, .i_bus_reset_in, .i_suspend, .i_cfg_we, .i_pme_event,
  .o_card_main_supply_sel0, .o_supply_sel_oe, .o_pme_n_oe, .i_cfg_main_sel, .o_state);
`default_nettype wire

/* File: tb/host_reset_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_reset_model (
  input wire logic i_clk_sys,
  input wire logic i_boot,
  input wire logic i_bus,
  input wire logic i_sleep,
  input wire logic i_strap,
  output logic o_global_reset_in,
  output logic o_bus_reset_in,
  output logic o_susp,
  output logic o_vr_n
);
  // falling edge keeps pins settled at the sampling edge
  always_ff @(negedge i_clk_sys)
  begin
    o_global_reset_in <= i_boot;
    o_bus_reset_in <= i_bus;
    o_susp <= i_sleep;
  end
  assign o_vr_n = i_strap;
endmodule
`default_nettype wire

/* File: tb/card_bridge_reset_suspend_test.sv */
`timescale 1ns/1ps
`default_nettype none
module card_bridge_reset_suspend_test;
  logic i_clk_sys = 1'h0, i_reset = 1'h1, boot = 1'h0, bus = 1'h0, sleep = 1'h0;
  logic i_cfg_we = 1'h0, i_cfg_pme_en = 1'h0, i_pme_event = 1'h0;
  logic strap = 1'h0;
  logic [1:0] i_cfg_main_sel = 2'h0, i_cfg_prog_sel = 2'h0, o_state;
  wire logic i_global_reset_in, i_bus_reset_in, i_suspend, i_regulator_enable_n;
  logic o_card_main_supply_sel0, o_card_main_supply_sel1, o_card_prog_supply_sel0;
  logic o_card_prog_supply_sel1, o_supply_sel_oe, o_pme_n_out, o_pme_n_oe, o_regulator_internal;
  wire logic [1:0] mw = {o_card_main_supply_sel1, o_card_main_supply_sel0};
  int err_total = 0, n_compared = 0;
  host_reset_model u_host_reset_model (.i_clk_sys(i_clk_sys), .i_boot(boot), .i_bus(bus),
    .i_sleep(sleep), .i_strap(strap),
    .o_global_reset_in(i_global_reset_in), .o_bus_reset_in(i_bus_reset_in), .o_susp(i_suspend),
    .o_vr_n(i_regulator_enable_n));
  card_bridge_reset_suspend u_card_bridge_reset_suspend (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_global_reset_in(i_global_reset_in),
    .i_bus_reset_in(i_bus_reset_in),
    .i_suspend(i_suspend),
    .i_regulator_enable_n(i_regulator_enable_n),
    .i_cfg_we(i_cfg_we),
    .i_cfg_main_sel(i_cfg_main_sel),
    .i_cfg_prog_sel(i_cfg_prog_sel),
    .i_cfg_pme_en(i_cfg_pme_en),
    .i_pme_event(i_pme_event),
    .o_card_main_supply_sel0(o_card_main_supply_sel0),
    .o_card_main_supply_sel1(o_card_main_supply_sel1),
    .o_card_prog_supply_sel0(o_card_prog_supply_sel0),
    .o_card_prog_supply_sel1(o_card_prog_supply_sel1),
    .o_supply_sel_oe(o_supply_sel_oe),
    .o_pme_n_out(o_pme_n_out),
    .o_pme_n_oe(o_pme_n_oe),
    .o_regulator_internal(o_regulator_internal),
    .o_state(o_state)
  );
  initial forever #4 i_clk_sys = ~i_clk_sys;
  task automatic chk(string n, logic [1:0] e, logic [1:0] v);
    n_compared++;
    if (v !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %b got %b", n, e, v);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_clk_sys);
  endtask
  task automatic wr(logic [1:0] m, logic [1:0] p, logic e);
    i_cfg_we = 1'h1;
    i_cfg_main_sel = m;
    i_cfg_prog_sel = p;
    i_cfg_pme_en = e;
    cyc(1);
    i_cfg_we = 1'h0;
    cyc(1);
  endtask
  task automatic t_write;
    wr(2'h3, 2'h2, 1'h0);
    wr(2'h1, 2'h2, 1'h0);
    chk("main", 2'h1, mw);
    chk("prog", 2'h2, {o_card_prog_supply_sel1, o_card_prog_supply_sel0});
    chk("vreg", 2'h1, {1'h0, o_regulator_internal});
    strap = 1'h1;
    cyc(4);
    chk("vreg", 2'h0, {1'h0, o_regulator_internal});
    strap = 1'h0;
    cyc(4);
  endtask
  task automatic t_bus_pme(logic en);
    wr(2'h3, 2'h3, en);
    bus <= 1'h1;
    cyc(5);
    chk("main", 2'h0, mw);
    chk("oe", 2'h0, {1'h0, o_supply_sel_oe});
    i_pme_event = 1'h1;
    cyc(1);
    i_pme_event = 1'h0;
    chk("pme", {1'h0, en}, {1'h0, o_pme_n_oe});
    chk("pme_out", 2'h0, {1'h0, o_pme_n_out});
    bus <= 1'h0;
    cyc(5);
    chk("state", 2'h0, o_state);
    chk("oe", 2'h1, {1'h0, o_supply_sel_oe});
  endtask
  task automatic t_susp;
    wr(2'h2, 2'h1, 1'h1);
    sleep <= 1'h1;
    bus <= 1'h1;
    cyc(5);
    chk("state", 2'h3, o_state);
    chk("kept", 2'h2, mw);
    chk("oe", 2'h0, {1'h0, o_supply_sel_oe});
    bus <= 1'h0;
    boot <= 1'h1;
    cyc(5);
    chk("kept", 2'h2, mw);
    chk("oe", 2'h0, {1'h0, o_supply_sel_oe});
    sleep <= 1'h0;
    cyc(5);
    chk("cleared", 2'h0, mw);
    chk("oe", 2'h0, {1'h0, o_supply_sel_oe});
    boot <= 1'h0;
    cyc(5);
    t_bus_pme(1'h0);
  endtask
  task results;
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    err_total++;
    results();
  end
  initial
  begin
    cyc(10);
    i_reset = 1'h0;
    cyc(3);
    t_write();
    t_bus_pme(1'h1);
    t_susp();
    results();
  end
endmodule
`default_nettype wire
